/* File: rtl/icc_map.vh */
// Register map, field positions and reset values of the controller slice
`ifndef ICC_MAP_VH
`define ICC_MAP_VH

// Register byte offsets
`define ICC_OFF_CLR_TXABRT   8'h54
`define ICC_OFF_CLR_NACK     8'h58
`define ICC_OFF_CLR_ACT      8'h5C
`define ICC_OFF_CLR_STOP     8'h60
`define ICC_OFF_CLR_START    8'h64
`define ICC_OFF_CLR_GCALL    8'h68
`define ICC_OFF_ENABLE       8'h6C
`define ICC_OFF_STATUS       8'h70
`define ICC_OFF_TX_FILL_COUNT        8'h74
`define ICC_OFF_RX_FILL_COUNT        8'h78
`define ICC_OFF_SDA_HOLD     8'h7C
`define ICC_OFF_ABRT_SRC     8'h80

// Raw interrupt flag positions
`define ICC_RAW_TXABRT       6
`define ICC_RAW_NACK         7
`define ICC_RAW_ACT          8
`define ICC_RAW_STOP         9
`define ICC_RAW_START        10
`define ICC_RAW_GCALL        11

// Enable register fields
`define ICC_EN_ENABLE        0
`define ICC_EN_ABORT         1

// Status register fields
`define ICC_ST_ACT           0
`define ICC_ST_TX_FIFO_NOT_FULL          1
`define ICC_ST_TFE           2
`define ICC_ST_RX_FIFO_NOT_EMPTY          3
`define ICC_ST_RFF           4
`define ICC_ST_MST           5
`define ICC_ST_SLV           6

// Abort reasons fields
`define ICC_AS_FLUSH_LSB     24
`define ICC_AS_CAUSE_W       17

// Reset values
`define ICC_RST_ENABLE       2'h0
`define ICC_RST_STATUS       7'h06
`define ICC_RST_SDA_HOLD     16'h0001
`define ICC_RST_LEVEL        4'h0
`define ICC_RST_ABRT_SRC     32'h00000000

`endif

/* File: rtl/icc_sync.v */
// Two flip-flop synchroniser for asynchronous inputs
`default_nettype none

module icc_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_srst,
  // Asynchronous input and synchronised output
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage feeds only the second stage
  always @(posedge i_clk) begin
    if (i_srst) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule

`default_nettype wire

/* File: rtl/icc_flags.v */
// Bank of sticky flags, set by hardware, cleared by software
`default_nettype none

module icc_flags #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_srst,
  // Set and clear strobes, one per flag
  input  wire [W-1:0] i_set,
  input  wire [W-1:0] i_clr,
  // Flag state
  output wire [W-1:0] o_flag
);

  reg [W-1:0] flag_r;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_flag
      // Set beats clear so an event in the clear cycle survives
      always @(posedge i_clk) begin
        if (i_srst) begin
          flag_r[g] <= 1'b0;
        end else if (i_set[g]) begin
          flag_r[g] <= 1'b1;
        end else if (i_clr[g]) begin
          flag_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign o_flag = flag_r;

endmodule

`default_nettype wire

/* File: rtl/icc_regs.v */
// Register slice of the two-wire bus controller with APB access
//
// Notes on behaviour
// - Abort clear read drops flag and reasons
// - Nack clear read drops slave nack flag
// - Activity clear read works only when idle
// - Stop clear read drops stop flag
// - Start clear read drops start flag
// - General call clear read drops flag
// - Abort bit set by write, clears when done
// - Enable bit zero, resets to zero
// - Status bit 6 shows slave busy
// - Status bit 5 shows master busy
// - Status bit 4 shows receive FIFO full
// - Status bit 3 shows receive FIFO nonempty
// - Status bit 2 shows transmit FIFO empty
// - Status bit 1 shows transmit FIFO room
// - Transmit level register reports entry count
// - Receive level register reports entry count
// - Sixteen-bit SDA hold, resets to one
// - Activity flag set by activity, sticky
// - Abort captures prior transmit level
//
// Added by the designer: the APB register port.
`include "icc_map.vh"
`default_nettype none

module icc_regs #(
  parameter FIFO_DEPTH = 8,
  parameter LVL_W      = 4
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_srst,
  // APB slave
  input  wire             i_psel,
  input  wire             i_penable,
  input  wire             i_pwrite,
  input  wire [7:0]       i_paddr,
  input  wire [31:0]      i_pwdata,
  input  wire [3:0]       i_pstrb,
  output wire             o_pready,
  output reg  [31:0]      o_prdata,
  output wire             o_pslverr,
  // Two-wire bus pins, observed only
  input  wire             i_scl,
  input  wire             i_sda,
  // Protocol engine status
  input  wire             i_mst_busy,
  input  wire             i_slv_busy,
  input  wire             i_tx_abort,
  input  wire [16:0]      i_abort_src,
  input  wire             i_slv_nack,
  input  wire             i_general_call_received_flag,
  input  wire             i_abort_done,
  input  wire [LVL_W-1:0] i_tx_fill_count,
  input  wire [LVL_W-1:0] i_rx_fill_count,
  // Controls towards the protocol engine
  output wire             o_enable,
  output wire             o_abort,
  output wire [15:0]      o_sda_hold_cycles,
  output wire [11:0]      o_raw_flags
);

  // Abort sequencer states
  localparam [1:0] ABT_IDLE = 2'b01;
  localparam [1:0] ABT_RUN  = 2'b10;

  // Flag bank indices
  localparam F_TXABRT = 0;
  localparam F_NACK   = 1;
  localparam F_ACT    = 2;
  localparam F_STOP   = 3;
  localparam F_START  = 4;
  localparam F_GCALL  = 5;
  localparam NFLAG    = 6;

  reg              enable_r;
  reg  [1:0]       abt_state_r;
  reg  [1:0]       abt_state_nxt;
  reg  [15:0]      sda_hold_r;
  reg  [6:0]       status_r;
  reg  [LVL_W-1:0] tx_lvl_r;
  reg  [LVL_W-1:0] rx_lvl_r;
  reg  [LVL_W-1:0] tx_lvl_prev_r;
  reg  [31:0]      abrt_src_r;
  reg              err_r;
  reg  [31:0]      rd_nxt;
  reg              err_nxt;
  reg              scl_d_r;
  reg              sda_d_r;
  wire [1:0]       pin_s;
  wire             scl_s;
  wire             sda_s;
  wire             start_evt;
  wire             stop_evt;
  wire             act_now;
  wire             setup;
  wire             access;
  wire             wr_acc;
  wire             rd_acc;
  wire [NFLAG-1:0] flag_set;
  wire [NFLAG-1:0] flag_clr;
  wire [NFLAG-1:0] flag;
  wire             abort_req;
  wire             tx_full;
  wire             rx_full;
  wire [6:0]       status_nxt;

  // APB phases; zero wait states, data prepared in setup
  // Error decoded in setup, so access never waits
  assign setup    = i_psel & ~i_penable;
  assign access   = i_psel & i_penable;
  assign o_pready = access;
  assign wr_acc   = access & i_pwrite;
  assign rd_acc   = access & ~i_pwrite;
  assign o_pslverr = access & err_r;

  // Bus pins come from another domain
  icc_sync #(
    .W (2)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async ({i_scl, i_sda}),
    .o_sync  (pin_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  // Previous pin levels for edge finding
  // Reset high like an idle bus; the synchroniser resets low, so release shows a falling edge on both pins
  always @(posedge i_clk) begin
    if (i_srst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // SDA moving while SCL stays high marks start or stop
  // Gated by enable; a disabled controller logs no bus events
  assign start_evt = enable_r & scl_d_r & scl_s & sda_d_r & ~sda_s;
  assign stop_evt  = enable_r & scl_d_r & scl_s & ~sda_d_r & sda_s;

  // Either state machine away from idle counts as activity
  assign act_now = i_mst_busy | i_slv_busy;

  // Hardware events raise sticky flags
  // Activity sets on every busy cycle, so set beats clear
  assign flag_set[F_TXABRT] = i_tx_abort;
  assign flag_set[F_NACK]   = i_slv_nack;
  assign flag_set[F_ACT]    = act_now;
  assign flag_set[F_STOP]   = stop_evt;
  assign flag_set[F_START]  = start_evt;
  assign flag_set[F_GCALL]  = i_general_call_received_flag;

  // Reads of the clear registers drop their flag
  // Activity clear is ignored while either machine is busy
  assign flag_clr[F_TXABRT] = rd_acc &
    (i_paddr == `ICC_OFF_CLR_TXABRT);
  assign flag_clr[F_NACK]   = rd_acc &
    (i_paddr == `ICC_OFF_CLR_NACK);
  assign flag_clr[F_ACT]    = rd_acc & ~act_now &
    (i_paddr == `ICC_OFF_CLR_ACT);
  assign flag_clr[F_STOP]   = rd_acc &
    (i_paddr == `ICC_OFF_CLR_STOP);
  assign flag_clr[F_START]  = rd_acc &
    (i_paddr == `ICC_OFF_CLR_START);
  assign flag_clr[F_GCALL]  = rd_acc &
    (i_paddr == `ICC_OFF_CLR_GCALL);

  icc_flags #(
    .W (NFLAG)
  ) u_flags (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_set  (flag_set),
    .i_clr  (flag_clr),
    .o_flag (flag)
  );

  // Raw flags at their fixed positions, others zero
  // No bus offset for these; the engine reads them here
  assign o_raw_flags = {flag[F_GCALL], flag[F_START], flag[F_STOP],
                        flag[F_ACT], flag[F_NACK], flag[F_TXABRT],
                        6'h00};

  // Software write of one starts an abort
  assign abort_req = wr_acc & i_pstrb[0] &
    (i_paddr == `ICC_OFF_ENABLE) & i_pwdata[`ICC_EN_ABORT];

  // Abort sequencer; a new request wins over a done pulse
  // Writing zero never cancels an abort in progress
  always @* begin
    abt_state_nxt = abt_state_r;
    case (abt_state_r)
      ABT_IDLE: begin
        if (abort_req) begin
          abt_state_nxt = ABT_RUN;
        end
      end
      ABT_RUN: begin
        if (i_abort_done && !abort_req) begin
          abt_state_nxt = ABT_IDLE;
        end
      end
      default: begin
        abt_state_nxt = ABT_IDLE;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      abt_state_r <= ABT_IDLE;
    end else begin
      abt_state_r <= abt_state_nxt;
    end
  end

  // Writable registers honour byte strobes; upper bits dropped
  // Upper lanes hold only reserved bits, so they are ignored
  always @(posedge i_clk) begin
    if (i_srst) begin
      enable_r   <= 1'b0;
      sda_hold_r <= `ICC_RST_SDA_HOLD;
    end else if (wr_acc) begin
      if (i_paddr == `ICC_OFF_ENABLE && i_pstrb[0]) begin
        enable_r <= i_pwdata[`ICC_EN_ENABLE];
      end
      if (i_paddr == `ICC_OFF_SDA_HOLD) begin
        if (i_pstrb[0]) begin
          sda_hold_r[7:0] <= i_pwdata[7:0];
        end
        if (i_pstrb[1]) begin
          sda_hold_r[15:8] <= i_pwdata[15:8];
        end
      end
    end
  end

  assign o_enable          = enable_r;
  assign o_abort           = abt_state_r[1];
  assign o_sda_hold_cycles = sda_hold_r;

  // FIFO occupancy compares, widened to avoid truncation
  assign tx_full = ({{(32-LVL_W){1'b0}}, tx_lvl_r} == FIFO_DEPTH);
  assign rx_full = ({{(32-LVL_W){1'b0}}, rx_lvl_r} == FIFO_DEPTH);

  // Status snapshot; FIFO bits from registered levels, busy and activity bits straight from the engine
  assign status_nxt[`ICC_ST_SLV]  = i_slv_busy;
  assign status_nxt[`ICC_ST_MST]  = i_mst_busy;
  assign status_nxt[`ICC_ST_RFF]  = rx_full;
  assign status_nxt[`ICC_ST_RX_FIFO_NOT_EMPTY] = (rx_lvl_r != {LVL_W{1'b0}});
  assign status_nxt[`ICC_ST_TFE]  = (tx_lvl_r == {LVL_W{1'b0}});
  assign status_nxt[`ICC_ST_TX_FIFO_NOT_FULL] = ~tx_full;
  assign status_nxt[`ICC_ST_ACT]  = act_now;

  // Level registers and status busy bits lag the engine by one cycle, status FIFO bits by two
  // Reads latch in setup, so software sees one cycle more of lag
  always @(posedge i_clk) begin
    if (i_srst) begin
      tx_lvl_r      <= {LVL_W{1'b0}};
      rx_lvl_r      <= {LVL_W{1'b0}};
      tx_lvl_prev_r <= {LVL_W{1'b0}};
      status_r      <= `ICC_RST_STATUS;
    end else begin
      tx_lvl_r      <= i_tx_fill_count;
      rx_lvl_r      <= i_rx_fill_count;
      tx_lvl_prev_r <= tx_lvl_r;
      status_r      <= status_nxt;
    end
  end

  // Abort reasons; a new abort beats a clearing read
  // Level taken one stage back, before the engine flushes
  always @(posedge i_clk) begin
    if (i_srst) begin
      abrt_src_r <= `ICC_RST_ABRT_SRC;
    end else if (i_tx_abort) begin
      abrt_src_r <= {{(8-LVL_W){1'b0}}, tx_lvl_prev_r,
                     7'h00, i_abort_src};
    end else if (flag_clr[F_TXABRT]) begin
      abrt_src_r <= 32'h00000000;
    end
  end

  // Read mux; clear registers always read zero
  // Unmapped offsets raise the slave error with zero data
  always @* begin
    rd_nxt  = 32'h00000000;
    err_nxt = 1'b0;
    case (i_paddr)
      `ICC_OFF_CLR_TXABRT,
      `ICC_OFF_CLR_NACK,
      `ICC_OFF_CLR_ACT,
      `ICC_OFF_CLR_STOP,
      `ICC_OFF_CLR_START,
      `ICC_OFF_CLR_GCALL: begin
        rd_nxt = 32'h00000000;
      end
      `ICC_OFF_ENABLE: begin
        rd_nxt = {30'h0, abt_state_r[1], enable_r};
      end
      `ICC_OFF_STATUS: begin
        rd_nxt = {25'h0, status_r};
      end
      `ICC_OFF_TX_FILL_COUNT: begin
        rd_nxt = {{(32-LVL_W){1'b0}}, tx_lvl_r};
      end
      `ICC_OFF_RX_FILL_COUNT: begin
        rd_nxt = {{(32-LVL_W){1'b0}}, rx_lvl_r};
      end
      `ICC_OFF_SDA_HOLD: begin
        rd_nxt = {16'h0000, sda_hold_r};
      end
      `ICC_OFF_ABRT_SRC: begin
        rd_nxt = abrt_src_r;
      end
      default: begin
        err_nxt = 1'b1;
      end
    endcase
  end

  // Read data captured in setup, stable through the access cycle
  // Writes load zero so stale data never leaks onto the bus
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_prdata <= 32'h00000000;
      err_r    <= 1'b0;
    end else if (setup) begin
      o_prdata <= i_pwrite ? 32'h00000000 : rd_nxt;
      err_r    <= err_nxt;
    end
  end

endmodule

`default_nettype wire

/* File: tb/icc_regs_asserts.sv */
// Port-level checks for the register slice, bound into its top module
`default_nettype none

module icc_regs_asserts (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_srst,
  // Register bus
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  // Engine side
  input wire logic        i_mst_busy,
  input wire logic        i_slv_busy,
  input wire logic        i_tx_abort,
  input wire logic        i_slv_nack,
  input wire logic        i_general_call_received_flag,
  input wire logic        i_abort_done,
  input wire logic        o_enable,
  input wire logic        o_abort,
  input wire logic [15:0] o_sda_hold_cycles,
  input wire logic [11:0] o_raw_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd;
  logic wr;

  // Access phase qualifiers
  assign rd = i_psel && i_penable && !i_pwrite;
  assign wr = i_psel && i_penable && i_pwrite;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  chk_abort_clear: assert property (
    rd && i_paddr == 8'h54 && !i_tx_abort |=> !o_raw_flags[6])
    else $error("abort flag survived its clear read");
  chk_nack_clear: assert property (
    rd && i_paddr == 8'h58 && !i_slv_nack |=> !o_raw_flags[7])
    else $error("nack flag survived its clear read");
  chk_act_busy_keep: assert property (
    rd && i_paddr == 8'h5C && (i_mst_busy || i_slv_busy) |=> o_raw_flags[8])
    else $error("activity flag cleared while busy");
  chk_gcall_clear: assert property (
    rd && i_paddr == 8'h68 && !i_general_call_received_flag |=> !o_raw_flags[11])
    else $error("general call flag survived its clear read");
  chk_abort_start: assert property (
    wr && i_paddr == 8'h6C && i_pstrb[0] && i_pwdata[1] |=> o_abort)
    else $error("abort request not taken");
  chk_abort_hold: assert property (
    o_abort && !i_abort_done |=> o_abort)
    else $error("abort dropped before done");
  chk_enable_load: assert property (
    wr && i_paddr == 8'h6C && i_pstrb[0] |=> o_enable == $past(i_pwdata[0]))
    else $error("enable bit not loaded");
  chk_hold_load: assert property (
    wr && i_paddr == 8'h7C && i_pstrb[1:0] == 2'h3
    |=> o_sda_hold_cycles == $past(i_pwdata[15:0]))
    else $error("hold time not loaded");
  chk_act_sticky: assert property (
    o_raw_flags[8] && !(rd && i_paddr == 8'h5C) |=> o_raw_flags[8])
    else $error("activity flag lost without clear");
  chk_unmapped_err: assert property (
    i_psel && i_penable && i_paddr == 8'h84 |-> o_pslverr && o_prdata == 0)
    else $error("unmapped access not refused");
endmodule

bind icc_regs icc_regs_asserts u_chk (
  .i_clk             (i_clk),
  .i_srst            (i_srst),
  .i_psel            (i_psel),
  .i_penable         (i_penable),
  .i_pwrite          (i_pwrite),
  .i_paddr           (i_paddr),
  .i_pwdata          (i_pwdata),
  .i_pstrb           (i_pstrb),
  .o_prdata          (o_prdata),
  .o_pslverr         (o_pslverr),
  .i_mst_busy        (i_mst_busy),
  .i_slv_busy        (i_slv_busy),
  .i_tx_abort        (i_tx_abort),
  .i_slv_nack        (i_slv_nack),
  .i_general_call_received_flag        (i_general_call_received_flag),
  .i_abort_done      (i_abort_done),
  .o_enable          (o_enable),
  .o_abort           (o_abort),
  .o_sda_hold_cycles (o_sda_hold_cycles),
  .o_raw_flags       (o_raw_flags)
);

`default_nettype wire

/* File: tb/icc_bus_dev.sv */
// Far-side bus device: one start, two clock pulses, one stop
`default_nettype none

module icc_bus_dev (
  // Trigger from the bench
  input  wire logic i_go,
  // Bus lines, pulled up when released
  output var logic  o_scl,
  output var logic  o_sda
);
  timeunit 1ns;
  timeprecision 1ns;

  // Lines idle high; clock stands still outside the frame
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Frame at an 800 ns link period
  always @(posedge i_go) begin
    #400 o_sda = 1'b0;
    repeat (2) begin
      #400 o_scl = 1'b0;
      #400 o_scl = 1'b1;
    end
    #400 o_sda = 1'b1;
  end
endmodule

`default_nettype wire

/* File: tb/tb_icc_regs.sv */
// Self-checking bench for the register slice
`default_nettype none

module tb_icc_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_srst = 1, psel = 0, pen = 0, pwr = 0, go = 0;
  logic mst = 0, slv = 0, txa = 0, nack = 0, gcall = 0, adone = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdat, seed = 32'h0754;
  logic [16:0] src = 17'h0;
  logic [3:0] txc = 4'h0, rxc = 4'h0, pstrb = 4'hF;
  logic [11:0] mf = 12'h0;
  logic perr;
  wire logic [31:0] prdata;
  wire logic [15:0] hold;
  wire logic [11:0] raw;
  wire logic pready, pslverr, enb, abt, scl, sda;
  int error_cnt = 0, checks = 0, cyc = 0;

  icc_regs dut (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_scl(scl), .i_sda(sda), .i_mst_busy(mst),
    .i_slv_busy(slv), .i_tx_abort(txa), .i_abort_src(src),
    .i_slv_nack(nack), .i_general_call_received_flag(gcall), .i_abort_done(adone),
    .i_tx_fill_count(txc), .i_rx_fill_count(rxc), .o_enable(enb),
    .o_abort(abt), .o_sda_hold_cycles(hold), .o_raw_flags(raw));
  icc_bus_dev bus (.i_go(go), .o_scl(scl), .o_sda(sda));

  // Clock and hang guard
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer; waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Extra edge lets a clearing read land before flags are looked at
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
    @(posedge i_clk);
  endtask

  // One-cycle engine event: 0 general call, 1 nack, 2 abort
  task automatic ev(input int k);
    @(posedge i_clk);
    gcall <= (k == 0);
    nack <= (k == 1);
    txa <= (k == 2);
    @(posedge i_clk);
    {gcall, nack, txa} <= 3'h0;
    @(posedge i_clk);
  endtask

  task automatic waitf(input int b);
    for (int n = 0; n < 100 && raw[b] !== 1'b1; n++) @(posedge i_clk);
  endtask

  task automatic summarize();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    int t, x;
    logic [31:0] r;
    logic [7:0] ca[3];
    int cb[3];
    ca = '{8'h68, 8'h58, 8'h54};
    cb = '{11, 7, 6};
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    for (int a = 8'h54; a <= 8'h80; a += 4)
      rdc(a[7:0], a == 8'h70 ? 6 : a == 8'h7C ? 1 : 0);
    apb(1'b0, 8'h84, 32'h0);
    chk({31'h0, perr}, 32'h1);
    chk(rdat, 32'h0);
    $display("test reset done");
    apb(1'b1, 8'h6C, 32'hFFFFFFFF);
    rdc(8'h6C, 32'h3);
    chk({abt, enb}, 2'h3);
    @(posedge i_clk) adone <= 1'b1;
    @(posedge i_clk) adone <= 1'b0;
    rdc(8'h6C, 32'h1);
    chk({abt, enb}, 2'h1);
    r = xs();
    apb(1'b1, 8'h7C, r);
    rdc(8'h7C, {16'h0, r[15:0]});
    chk(hold, r[15:0]);
    pstrb <= 4'h1;
    apb(1'b1, 8'h7C, ~r);
    pstrb <= 4'hF;
    rdc(8'h7C, {16'h0, r[15:8], ~r[7:0]});
    $display("test control done");
    for (int i = 0; i < 10; i++) begin
      r = xs();
      t = i == 0 ? 8 : i == 1 ? 0 : r % 9;
      x = i == 0 ? 8 : i == 1 ? 0 : (r >> 8) % 9;
      txc <= t[3:0];
      rxc <= x[3:0];
      mst <= r[16] && i > 1;
      slv <= r[17] && i > 1;
      repeat (4) @(posedge i_clk);
      if (mst || slv) mf[8] = 1'b1;
      rdc(8'h70, {slv, mst, x == 8, x != 0, t == 0, t != 8, mst | slv});
      rdc(8'h74, t);
      rdc(8'h78, x);
    end
    chk(raw, mf);
    mst <= 1'b1;
    slv <= 1'b0;
    repeat (3) @(posedge i_clk);
    mf[8] = 1'b1;
    rdc(8'h5C, 32'h0);
    chk(raw, mf);
    mst <= 1'b0;
    repeat (3) @(posedge i_clk);
    rdc(8'h5C, 32'h0);
    mf[8] = 1'b0;
    chk(raw, mf);
    $display("test status done");
    txc <= 4'h5;
    for (int k = 0; k < 3; k++) begin
      src <= 17'(xs());
      ev(k);
      mf[cb[k]] = 1'b1;
      chk(raw, mf);
      if (k == 2) rdc(8'h80, {8'h05, 7'h0, src});
      rdc(ca[k], 32'h0);
      mf[cb[k]] = 1'b0;
      chk(raw, mf);
    end
    rdc(8'h80, 32'h0);
    $display("test events done");
    go <= 1'b1;
    waitf(10);
    waitf(9);
    mf[10:9] = 2'h3;
    chk(raw, mf);
    rdc(8'h64, 32'h0);
    rdc(8'h60, 32'h0);
    mf[10:9] = 2'h0;
    chk(raw, mf);
    $display("test pins done");
    summarize();
  end
endmodule

`default_nettype wire
